// ==== src/dsp_map.svh ====
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH
`define DSP_CLK_HZ 40000000
`define DSP_BAUD_19200 19200
`define DSP_BAUD_9600 9600
`define DSP_BAUD_4800 4800
`define DSP_BAUD_2400 2400
`define DSP_BAUD_1200 1200
`define DSP_BAUD_300 300
`define DSP_OFS_CTRL 8'h00
`define DSP_OFS_STAGE0 8'h04
`define DSP_OFS_STAGE1 8'h08
`define DSP_OFS_CMD 8'h0c
`define DSP_OFS_ACT0 8'h10
`define DSP_OFS_ACT1 8'h14
`define DSP_OFS_TXD 8'h18
`define DSP_OFS_RXD0 8'h1c
`define DSP_OFS_RXD1 8'h20
`define DSP_OFS_RXDEF 8'h24
`define DSP_OFS_STATUS 8'h28
`define DSP_CTRL_PROG 0
`define DSP_CTRL_HOST_EN 1
`define DSP_CTRL_TOOL 2
`define DSP_CTRL_DIFF 3
`define DSP_CMD_APPLY 0
`define DSP_CMD_HOST_DONE 1
`define DSP_TXD_SEL 8
`define DSP_RXD_VALID 8
`define DSP_CTRL_RST 5'h00
`define DSP_CFG_RST 15'h5600
`define DSP_CHAR_XON 8'h11
`define DSP_CHAR_XOFF 8'h13
`define DSP_CHAR_EOM 8'h0d
`endif

// ==== src/dsp_pkg.sv ====
package dsp_pkg;
    typedef struct packed {
        logic sw_flow;
        logic auto_echo;
        logic lf_after_cr;
        logic rx_always_on;
        logic stop_tx_on_rx;
        logic backspace;
        logic [1:0] stop;
        logic [1:0] parity;
        logic [1:0] bits;
        logic [2:0] baud;
    } dsp_cfg_type;
    typedef enum logic [1:0] {
        DSP_PAR_NONE = 2'b00,
        DSP_PAR_EVEN = 2'b01,
        DSP_PAR_ODD = 2'b10
    } dsp_par_type;
    typedef enum logic [2:0] {
        DSP_IDLE = 3'b000,
        DSP_START = 3'b001,
        DSP_DATA = 3'b010,
        DSP_PAR = 3'b011,
        DSP_STOP = 3'b100
    } dsp_state_type;
endpackage : dsp_pkg

// ==== src/dsp_serial_ports.sv ====
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "dsp_map.svh"
// How it works
// - Two ports, each sends and receives independently only with rx_always_on set and stop_tx_on_rx clear
// - Port one programs by default until reassigned
// - Programming port is plain serial without tool
// - Other port is host-polled, else plain serial
// - Host-polled port only answers, never initiates
// - Power-up loads default framing into both ports
// - Reset restores both ports' default parameters
// - Parameters change only on reconfiguration command
// - Defaults: 19200 baud, 8 bits, 2 stop, none
// - Requests without port go to programming port
// - Single-ended honours handshake, differential ignores it
module dsp_serial_ports #(
    parameter int CLK_HZ = `DSP_CLK_HZ
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] rxd,
    input wire logic [1:0] cts_n,
    output logic [1:0] txd,
    output logic [1:0] rts_n
);
    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [4:0] ctrl_q;
    dsp_pkg::dsp_cfg_type stage_q [2];
    dsp_pkg::dsp_cfg_type act_q [2];
    logic acc;
    logic wr;
    logic rd;
    logic [1:0] wr_tx;
    logic [1:0] pop;
    logic [1:0][7:0] st;
    logic [1:0][8:0] rxv;
    logic [31:0] rdata;
    logic hit;

    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    function automatic logic [19:0] half_div(input logic [2:0] code);
        int unsigned baud;
        unique case (code)
            3'h0: baud = `DSP_BAUD_19200;
            3'h1: baud = `DSP_BAUD_9600;
            3'h2: baud = `DSP_BAUD_4800;
            3'h3: baud = `DSP_BAUD_2400;
            3'h4: baud = `DSP_BAUD_1200;
            3'h5: baud = `DSP_BAUD_300;
            default: baud = `DSP_BAUD_19200;
        endcase
        return 20'(CLK_HZ / (2 * baud));
    endfunction : half_div

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0;
        unique case (paddr)
            `DSP_OFS_CTRL: rdata = {27'h0, ctrl_q};
            `DSP_OFS_STAGE0: rdata = {17'h0, stage_q[0]};
            `DSP_OFS_STAGE1: rdata = {17'h0, stage_q[1]};
            `DSP_OFS_CMD: rdata = 32'h0;
            `DSP_OFS_ACT0: rdata = {17'h0, act_q[0]};
            `DSP_OFS_ACT1: rdata = {17'h0, act_q[1]};
            `DSP_OFS_TXD: rdata = 32'h0;
            `DSP_OFS_RXD0: rdata = {23'h0, rxv[0]};
            `DSP_OFS_RXD1: rdata = {23'h0, rxv[1]};
            `DSP_OFS_RXDEF: rdata = {23'h0, rxv[ctrl_q[`DSP_CTRL_PROG]]};
            `DSP_OFS_STATUS: rdata = {16'h0, st[1], st[0]};
            default: hit = 1'b0;
        endcase
    end

    // One wait state, then answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit;
            if (psel & penable & ~pready_q) begin
                prdata_q <= pwrite ? 32'h0 : rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `DSP_CTRL_RST;
        end else if (wr && paddr == `DSP_OFS_CTRL) begin
            ctrl_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_q[0] <= `DSP_CFG_RST;
            stage_q[1] <= `DSP_CFG_RST;
            act_q[0] <= `DSP_CFG_RST;
            act_q[1] <= `DSP_CFG_RST;
        end else begin
            if (wr && paddr == `DSP_OFS_STAGE0) begin
                stage_q[0] <= pwdata[14:0];
            end
            if (wr && paddr == `DSP_OFS_STAGE1) begin
                stage_q[1] <= pwdata[14:0];
            end
            if (wr && paddr == `DSP_OFS_CMD && pwdata[`DSP_CMD_APPLY]) begin
                act_q[0] <= stage_q[0];
                act_q[1] <= stage_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial ports
    // Two independent channels
    for (genvar i = 0; i < 2; i++) begin : g_port
        localparam logic IDX = 1'(i);
        dsp_pkg::dsp_cfg_type c;
        dsp_pkg::dsp_state_type tx_st;
        dsp_pkg::dsp_state_type rx_st;
        logic [19:0] hd;
        logic [19:0] tx_left;
        logic [19:0] rx_left;
        logic [19:0] stop_len;
        logic [7:0] mask;
        logic [7:0] hold_q;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [7:0] rx_char;
        logic [7:0] rx_data_q;
        logic [2:0] tx_n;
        logic [2:0] rx_n;
        logic [2:0] rx_s;
        logic [2:0] cts_s;
        logic rx_q;
        logic cts_q;
        logic full_q;
        logic tx_par;
        logic rx_pbit;
        logic prog;
        logic diff;
        logic host_act;
        logic host_turn_q;
        logic paused_q;
        logic rx_valid_q;
        logic ovr_q;
        logic ferr_q;
        logic perr_q;
        logic tx_start;
        logic rx_done;
        logic rx_ok;
        logic rx_perr;
        logic flow_char;
        logic deliver;

        assign c = act_q[i];
        assign hd = half_div(c.baud);
        assign mask = 8'hff >> c.bits;
        assign stop_len = 20'(hd * (3'h4 - {1'b0, c.stop}));
        assign prog = ctrl_q[`DSP_CTRL_PROG] == IDX;
        assign diff = ctrl_q[`DSP_CTRL_DIFF + i];
        assign host_act = ctrl_q[`DSP_CTRL_HOST_EN] & ~prog;
        assign wr_tx[i] = wr && paddr == `DSP_OFS_TXD &&
            (pwdata[9:8] == 2'(i + 1) || (pwdata[9:8] == 2'h0 && prog));
        assign pop[i] = rd && (paddr == (IDX ? `DSP_OFS_RXD1 : `DSP_OFS_RXD0) ||
            (paddr == `DSP_OFS_RXDEF && prog));
        assign rxv[i] = {rx_valid_q, rx_data_q};
        assign st[i] = {host_turn_q, paused_q, perr_q, ferr_q, ovr_q, rx_valid_q,
            tx_st != dsp_pkg::DSP_IDLE, full_q};
        // Data port speaks only after host
        assign tx_start = tx_st == dsp_pkg::DSP_IDLE && full_q && !paused_q &&
            (diff || !cts_q) && (!host_act || host_turn_q) &&
            !(c.stop_tx_on_rx && rx_st != dsp_pkg::DSP_IDLE);
        assign rx_char = rx_sh >> c.bits;
        assign rx_perr = c.parity != dsp_pkg::DSP_PAR_NONE &&
            (rx_pbit != (^rx_char ^ (c.parity == dsp_pkg::DSP_PAR_ODD)));
        assign rx_done = rx_st == dsp_pkg::DSP_STOP && rx_left == 20'h0;
        assign rx_ok = rx_q && !rx_perr;
        assign flow_char = c.sw_flow &&
            (rx_char == `DSP_CHAR_XON || rx_char == `DSP_CHAR_XOFF);
        assign deliver = rx_done && rx_ok && !flow_char &&
            !(prog && ctrl_q[`DSP_CTRL_TOOL]);

        // Pin synchronisers
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rx_s <= 3'h7;
                cts_s <= 3'h7;
                rx_q <= 1'b1;
                cts_q <= 1'b1;
            end else begin
                rx_s <= {rx_s[1:0], rxd[i]};
                cts_s <= {cts_s[1:0], cts_n[i]};
                if (rx_s[2] == rx_s[1]) begin
                    rx_q <= rx_s[1];
                end
                if (cts_s[2] == cts_s[1]) begin
                    cts_q <= cts_s[1];
                end
            end
        end

        // Holding register and echo
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                full_q <= 1'b0;
                hold_q <= 8'h0;
            end else begin
                if (tx_start) begin
                    full_q <= 1'b0;
                end
                if (wr_tx[i] && !full_q && !(prog && ctrl_q[`DSP_CTRL_TOOL])) begin
                    hold_q <= pwdata[7:0];
                    full_q <= 1'b1;
                end else if (deliver && c.auto_echo && !full_q) begin
                    hold_q <= rx_char;
                    full_q <= 1'b1;
                end
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                tx_st <= dsp_pkg::DSP_IDLE;
                tx_left <= 20'h0;
                tx_sh <= 8'h0;
                tx_n <= 3'h0;
                tx_par <= 1'b0;
                txd[i] <= 1'b1;
            end else if (tx_left != 20'h0) begin
                tx_left <= tx_left - 20'h1;
            end else begin
                unique case (tx_st)
                    dsp_pkg::DSP_IDLE: begin
                        if (tx_start) begin
                            tx_sh <= hold_q;
                            tx_par <= ^(hold_q & mask) ^ (c.parity == dsp_pkg::DSP_PAR_ODD);
                            tx_n <= 3'(3'h7 - {1'b0, c.bits});
                            txd[i] <= 1'b0;
                            tx_left <= {hd[18:0], 1'b0} - 20'h1;
                            tx_st <= dsp_pkg::DSP_START;
                        end
                    end
                    dsp_pkg::DSP_START: begin
                        txd[i] <= tx_sh[0];
                        tx_left <= {hd[18:0], 1'b0} - 20'h1;
                        tx_st <= dsp_pkg::DSP_DATA;
                    end
                    dsp_pkg::DSP_DATA: begin
                        tx_left <= {hd[18:0], 1'b0} - 20'h1;
                        if (tx_n != 3'h0) begin
                            tx_sh <= tx_sh >> 1;
                            txd[i] <= tx_sh[1];
                            tx_n <= tx_n - 3'h1;
                        end else if (c.parity != dsp_pkg::DSP_PAR_NONE) begin
                            txd[i] <= tx_par;
                            tx_st <= dsp_pkg::DSP_PAR;
                        end else begin
                            txd[i] <= 1'b1;
                            tx_left <= stop_len - 20'h1;
                            tx_st <= dsp_pkg::DSP_STOP;
                        end
                    end
                    dsp_pkg::DSP_PAR: begin
                        txd[i] <= 1'b1;
                        tx_left <= stop_len - 20'h1;
                        tx_st <= dsp_pkg::DSP_STOP;
                    end
                    dsp_pkg::DSP_STOP: tx_st <= dsp_pkg::DSP_IDLE;
                    default: tx_st <= dsp_pkg::DSP_IDLE;
                endcase
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rx_st <= dsp_pkg::DSP_IDLE;
                rx_left <= 20'h0;
                rx_sh <= 8'h0;
                rx_n <= 3'h0;
                rx_pbit <= 1'b0;
            end else if (rx_left != 20'h0) begin
                rx_left <= rx_left - 20'h1;
            end else begin
                unique case (rx_st)
                    dsp_pkg::DSP_IDLE: begin
                        if (!rx_q && (c.rx_always_on || tx_st == dsp_pkg::DSP_IDLE)) begin
                            rx_left <= hd - 20'h1;
                            rx_st <= dsp_pkg::DSP_START;
                        end
                    end
                    dsp_pkg::DSP_START: begin
                        rx_left <= {hd[18:0], 1'b0} - 20'h1;
                        rx_n <= 3'(3'h7 - {1'b0, c.bits});
                        rx_st <= rx_q ? dsp_pkg::DSP_IDLE : dsp_pkg::DSP_DATA;
                    end
                    dsp_pkg::DSP_DATA: begin
                        rx_sh <= {rx_q, rx_sh[7:1]};
                        rx_left <= {hd[18:0], 1'b0} - 20'h1;
                        rx_n <= rx_n - 3'h1;
                        if (rx_n == 3'h0) begin
                            rx_st <= (c.parity != dsp_pkg::DSP_PAR_NONE) ?
                                dsp_pkg::DSP_PAR : dsp_pkg::DSP_STOP;
                        end
                    end
                    dsp_pkg::DSP_PAR: begin
                        rx_pbit <= rx_q;
                        rx_left <= {hd[18:0], 1'b0} - 20'h1;
                        rx_st <= dsp_pkg::DSP_STOP;
                    end
                    dsp_pkg::DSP_STOP: rx_st <= dsp_pkg::DSP_IDLE;
                    default: rx_st <= dsp_pkg::DSP_IDLE;
                endcase
            end
        end

        // Receive buffer and errors, set beats clear
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rx_valid_q <= 1'b0;
                rx_data_q <= 8'h0;
                ovr_q <= 1'b0;
                ferr_q <= 1'b0;
                perr_q <= 1'b0;
            end else begin
                if (pop[i]) begin
                    rx_valid_q <= 1'b0;
                    ovr_q <= 1'b0;
                    ferr_q <= 1'b0;
                    perr_q <= 1'b0;
                end
                if (deliver) begin
                    rx_data_q <= rx_char;
                    rx_valid_q <= 1'b1;
                    if (rx_valid_q && !pop[i]) begin
                        ovr_q <= 1'b1;
                    end
                end
                if (rx_done && !rx_q) begin
                    ferr_q <= 1'b1;
                end
                if (rx_done && rx_perr) begin
                    perr_q <= 1'b1;
                end
            end
        end

        // Pause on XOFF, resume on XON
        // Host turn opened by host character
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                paused_q <= 1'b0;
                host_turn_q <= 1'b0;
            end else begin
                if (!c.sw_flow) begin
                    paused_q <= 1'b0;
                end else if (rx_done && rx_ok && rx_char == `DSP_CHAR_XOFF) begin
                    paused_q <= 1'b1;
                end else if (rx_done && rx_ok && rx_char == `DSP_CHAR_XON) begin
                    paused_q <= 1'b0;
                end
                if (rx_done && rx_ok && host_act) begin
                    host_turn_q <= 1'b1;
                end else if ((wr && paddr == `DSP_OFS_CMD && pwdata[`DSP_CMD_HOST_DONE]) ||
                    !host_act) begin
                    host_turn_q <= 1'b0;
                end
            end
        end

        // Ready to receive, fixed in differential
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rts_n[i] <= 1'b1;
            end else begin
                rts_n[i] <= !diff && rx_valid_q;
            end
        end
    end
endmodule : dsp_serial_ports

// ==== test/dsp_serial_props.sv ====
`timescale 1ns/1ps
module dsp_serial_props #(
    parameter int CLK_HZ = 40000000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] rxd,
    input wire logic [1:0] cts_n,
    input wire logic [1:0] txd,
    input wire logic [1:0] rts_n
);
    default clocking dflt @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> psel && penable)
        else $error("ready without access");
    AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    AST_UNMAPPED: assert property (pready && paddr > 8'h28 |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    AST_RESET_IDLE: assert property ($rose(nrst) |-> txd == 2'b11)
        else $error("lines not idle after reset");
    AST_START_ONE: assert property ($fell(txd[0]) |-> (!txd[0])[*8])
        else $error("port one start bit short");
    AST_START_TWO: assert property ($fell(txd[1]) |-> (!txd[1])[*8])
        else $error("port two start bit short");
endmodule : dsp_serial_props
////////////////////////////////////////////////////////////
bind dsp_serial_ports dsp_serial_props #(.CLK_HZ(CLK_HZ)) u_dsp_serial_props (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));

// ==== test/dsp_term.sv ====
`timescale 1ns/1ps
module dsp_term #(
    parameter int BIT = 20
) (
    input wire logic clk,
    input wire logic [1:0] txd,
    input wire logic [1:0] rts_n,
    output logic [1:0] rxd,
    output logic [1:0] cts_n
);
    initial begin
        rxd = 2'b11;
        cts_n = 2'b00;
    end
    task automatic send(input int p, input logic [7:0] ch);
        logic [10:0] fr;
        fr = {2'b11, ch, 1'b0};
        while (rts_n[p] !== 1'b0) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            rxd[p] <= fr[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask : send
    task automatic flow(input int p, input logic v);
        cts_n[p] <= v;
    endtask : flow
    task automatic recv(input int p, input int lim, output logic [7:0] ch, output bit ok);
        int n;
        n = 0;
        ok = 0;
        ch = 8'h00;
        while (txd[p] !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) return;
        repeat (BIT / 2) @(posedge clk);
        ok = !txd[p];
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            ch[i] = txd[p];
        end
        repeat (BIT) @(posedge clk);
        ok = ok && txd[p];
        repeat (BIT) @(posedge clk);
        ok = ok && txd[p];
    endtask : recv
endmodule : dsp_term

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
    localparam int CLK_HZ = 384000;
    localparam int BIT = 2 * (CLK_HZ / (2 * 19200));
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, ch, got;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] rxd, cts_n, txd, rts_n;
    logic [14:0] stage_m[2];
    int n_errors = 0;
    int checks_done = 0;
    bit ok;
    dsp_serial_ports #(.CLK_HZ(CLK_HZ)) u_dsp_serial_ports (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n),
        .txd(txd), .rts_n(rts_n));
    dsp_term #(.BIT(BIT)) u_dsp_term (.clk(clk), .txd(txd), .rts_n(rts_n), .rxd(rxd),
        .cts_n(cts_n));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        `CHK("wait", 2, n)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    task automatic tx_chk(input logic [1:0] sel, input int p);
        ch = 8'h20 + 8'($urandom % 95);
        apb(1'b1, 8'h18, {22'h0, sel, ch});
        u_dsp_term.recv(p, 8 * BIT, got, ok);
        `CHK("tx frame", 1'b1, ok)
        `CHK("tx char", ch, got)
    endtask : tx_chk
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        close_out();
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(1273));
        do_reset();
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            `CHK("act", 32'h5600, rd)
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 1'b1, er)
        for (int s = 0; s < 3; s++) tx_chk(2'(s), s == 0 ? 0 : s - 1);
        for (int p = 0; p < 2; p++) begin
            ch = 8'h20 + 8'($urandom % 95);
            u_dsp_term.send(p, ch);
            `CHK("rts", 1'b1, rts_n[p])
            apb(1'b0, p == 0 ? 8'h24 : 8'h20, 32'h0);
            `CHK("rx", {23'h0, 1'b1, ch}, rd)
            @(posedge clk);
            `CHK("rts", 1'b0, rts_n[p])
        end
        u_dsp_term.flow(0, 1'b1);
        repeat (8) @(posedge clk);
        apb(1'b1, 8'h18, 32'h141);
        repeat (3 * BIT) @(posedge clk);
        `CHK("cts hold", 1'b1, txd[0])
        apb(1'b1, 8'h00, 32'h8);
        u_dsp_term.recv(0, 8 * BIT, got, ok);
        `CHK("diff tx", 8'h41, got)
        repeat (BIT) @(posedge clk);
        ch = 8'h20 + 8'($urandom % 95);
        u_dsp_term.send(0, ch);
        `CHK("rts diff", 1'b0, rts_n[0])
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("rx diff", {23'h0, 1'b1, ch}, rd)
        u_dsp_term.flow(0, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        tx_chk(2'd0, 1);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h18, 32'h241);
        repeat (3 * BIT) @(posedge clk);
        `CHK("host idle", 1'b1, txd[1])
        fork
            u_dsp_term.send(1, 8'h52);
            u_dsp_term.recv(1, 20 * BIT, got, ok);
        join
        `CHK("host reply", 8'h41, got)
        apb(1'b0, 8'h20, 32'h0);
        apb(1'b1, 8'h0c, 32'h2);
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h18, 32'h41);
        apb(1'b0, 8'h28, 32'h0);
        `CHK("tool refuse", 1'b0, rd[0])
        apb(1'b1, 8'h00, 32'h0);
        for (int i = 0; i < 2; i++) begin
            stage_m[i] = {6'($urandom), 2'($urandom % 3), 2'($urandom % 3),
                2'($urandom % 3), 3'($urandom % 6)};
            apb(1'b1, 8'h04 + 8'(4 * i), {17'h0, stage_m[i]});
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            `CHK("act held", 32'h5600, rd)
        end
        apb(1'b1, 8'h0c, 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            `CHK("act new", {17'h0, stage_m[i]}, rd)
        end
        do_reset();
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
            `CHK("act reset", 32'h5600, rd)
        end
        close_out();
    end
endmodule : tb_top
